/* common/hrs_consts.svh */
// Timing constants and field values for the hub reset and configuration sequencer
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH
`define HRS_CLK_HZ            10000000
`define HRS_STAB_MAX_US       500
`define HRS_STAB_CYC          ((`HRS_STAB_MAX_US * (`HRS_CLK_HZ / 1000000)))
`define HRS_EE_MAX_US         99500
`define HRS_EE_MAX_CYC        ((`HRS_EE_MAX_US * (`HRS_CLK_HZ / 1000000)))
`define HRS_ATTACH_MAX_US     100000
`define HRS_ATTACH_CYC        ((`HRS_ATTACH_MAX_US * (`HRS_CLK_HZ / 1000000)))
`define HRS_SMB_BP_MAX_US     99500
`define HRS_SMB_BP_MAX_CYC    ((`HRS_SMB_BP_MAX_US * (`HRS_CLK_HZ / 1000000)))
`define HRS_REQ_MAX_US        5000
`define HRS_REQ_MAX_CYC       ((`HRS_REQ_MAX_US * (`HRS_CLK_HZ / 1000000)))
`define HRS_DEFAULT_ADDR      7'h00
`define HRS_CNT_W             20
`endif

/* common/hrs_pkg.sv */
// Types shared by the hub reset and configuration sequencer
`default_nettype none
package hrs_pkg;
    typedef enum logic [6:0] {
        HRS_ST_STAB   = 7'h01,
        HRS_ST_EE     = 7'h02,
        HRS_ST_SMB    = 7'h04,
        HRS_ST_CFG    = 7'h08,
        HRS_ST_ATTACH = 7'h10,
        HRS_ST_RUN    = 7'h20,
        HRS_ST_FAULT  = 7'h40
    } hrs_state_t;

    typedef struct packed {
        logic       configured;
        logic       suspended;
        logic [6:0] dev_addr;
    } hrs_usb_state_t;
endpackage
`default_nettype wire

/* hw/hrs_timer.sv */
// Down-counting cycle timer with one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
`include "hrs_consts.svh"
module hrs_timer (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  load_i,
    input  wire logic [`HRS_CNT_W-1:0] count_i,
    output logic                       busy_o,
    output logic                       expire_o
);
    logic [`HRS_CNT_W-1:0] cnt_reg;
    logic [`HRS_CNT_W-1:0] cnt_next;
    logic                  exp_reg;
    logic                  exp_next;

    always_comb begin
        cnt_next = cnt_reg;
        exp_next = 1'b0;
        if (load_i) begin
            cnt_next = count_i;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - `HRS_CNT_W'(1);
            exp_next = (cnt_reg == `HRS_CNT_W'(1));
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= '0;
            exp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            exp_reg <= exp_next;
        end
    end

    assign busy_o   = (cnt_reg != '0);
    assign expire_o = exp_reg;
endmodule
`default_nettype wire

/* hw/hrs_sequencer.sv */
// Hub start-up sequencing, configuration load supervision and bus-reset handling
// Summary of operation
// - After reset release the hub waits its 500 us stabilisation time before configuring.
// - In EEPROM mode the configuration read must finish within 99.5 ms, else a fault is flagged.
// - In EEPROM mode the hub attaches upstream at most 100 ms after configuration completes.
// - After bus reset and idle, every host request is answered within 5 ms; the code only raises req_timeout_o when req_done_i misses that limit.
// - In SMBus mode the hub attaches at most 100 ms after the load ends.
// - A self-powered hub configured over SMBus waits for the load however long it takes.
// - A bus reset returns the device address to zero.
// - A bus reset returns the hub to the unconfigured state.
// - A bus reset switches off power to both downstream ports.
// - A bus reset discards all transaction translator buffers.
// - A bus reset while suspended makes the hub active again.
// - An upstream bus reset is never passed to downstream devices.
// - Once the stabilisation time ends the hub starts the EEPROM fetch unless SMBus mode is chosen.
`timescale 1ns/1ps
`default_nettype none
`include "hrs_consts.svh"
module hrs_sequencer (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       smbus_mode_i,
    input  wire logic       self_powered_i,
    input  wire logic       ee_done_i,
    input  wire logic       smb_load_done_i,
    input  wire logic       cfg_apply_done_i,
    input  wire logic       bus_reset_i,
    input  wire logic       suspend_i,
    input  wire logic       set_addr_i,
    input  wire logic [6:0] set_addr_val_i,
    input  wire logic       set_config_i,
    input  wire logic [1:0] port_power_req_i,
    input  wire logic       req_start_i,
    input  wire logic       req_done_i,
    output logic            ee_fetch_start_o,
    output logic            cfg_apply_start_o,
    output logic            attach_o,
    output logic [1:0]      downstream_port_power_en_o,
    output logic            downstream_reset_o,
    output logic            tt_flush_o,
    output logic            suspended_o,
    output logic            configured_o,
    output logic [6:0]      dev_addr_o,
    output logic            cfg_fault_o,
    output logic            req_timeout_o
);
    hrs_pkg::hrs_state_t     st_reg;
    hrs_pkg::hrs_state_t     st_next;
    hrs_pkg::hrs_usb_state_t usb_reg;
    hrs_pkg::hrs_usb_state_t usb_next;
    logic [1:0]              pwr_reg;
    logic [1:0]              pwr_next;
    logic                    start_reg;
    logic                    start_next;
    logic                    apply_reg;
    logic                    apply_next;
    logic                    flush_reg;
    logic                    flush_next;
    logic                    fault_reg;
    logic                    fault_next;
    logic                    req_act_reg;
    logic                    req_act_next;
    logic                    rto_reg;
    logic                    rto_next;
    logic                    smb_was_reg;
    logic                    smb_was_next;

    logic                    tmr_load;
    logic [`HRS_CNT_W-1:0]   tmr_count;
    logic                    tmr_exp;
    logic                    rq_load;
    logic                    rq_exp;
    logic                    armed_reg;
    logic                    stab_load;

    // Phase timer shared by every sequencing step
    hrs_timer u_phase_tmr (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .load_i    (tmr_load),
        .count_i   (tmr_count),
        .busy_o    (),
        .expire_o  (tmr_exp)
    );

    // Separate request timer so bus activity never disturbs sequencing
    hrs_timer u_req_tmr (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .load_i    (rq_load),
        .count_i   (`HRS_CNT_W'(`HRS_REQ_MAX_CYC)),
        .busy_o    (),
        .expire_o  (rq_exp)
    );

    always_comb begin
        st_next      = st_reg;
        start_next   = 1'b0;
        apply_next   = 1'b0;
        fault_next   = fault_reg;
        smb_was_next = smb_was_reg;
        tmr_load     = 1'b0;
        tmr_count    = '0;
        case (st_reg)
            hrs_pkg::HRS_ST_STAB: begin
                if (stab_load) begin
                    tmr_load  = 1'b1;
                    tmr_count = `HRS_CNT_W'(`HRS_STAB_CYC);
                end else if (tmr_exp) begin
                    tmr_load = 1'b1;
                    smb_was_next = smbus_mode_i;
                    if (smbus_mode_i) begin
                        st_next   = hrs_pkg::HRS_ST_SMB;
                        tmr_count = `HRS_CNT_W'(`HRS_SMB_BP_MAX_CYC);
                    end else begin
                        st_next    = hrs_pkg::HRS_ST_EE;
                        start_next = 1'b1;
                        tmr_count  = `HRS_CNT_W'(`HRS_EE_MAX_CYC);
                    end
                end
            end
            hrs_pkg::HRS_ST_EE: begin
                if (ee_done_i) begin
                    st_next    = hrs_pkg::HRS_ST_CFG;
                    apply_next = 1'b1;
                    tmr_load   = 1'b1;
                    tmr_count  = `HRS_CNT_W'(`HRS_ATTACH_CYC);
                end else if (tmr_exp) begin
                    st_next    = hrs_pkg::HRS_ST_FAULT;
                    fault_next = 1'b1;
                end
            end
            hrs_pkg::HRS_ST_SMB: begin
                if (smb_load_done_i) begin
                    st_next    = hrs_pkg::HRS_ST_CFG;
                    apply_next = 1'b1;
                    tmr_load   = 1'b1;
                    tmr_count  = `HRS_CNT_W'(`HRS_ATTACH_CYC);
                end else if (tmr_exp && !self_powered_i) begin
                    st_next    = hrs_pkg::HRS_ST_FAULT;
                    fault_next = 1'b1;
                end
                // Self-powered: no limit, keep waiting for the host
            end
            hrs_pkg::HRS_ST_CFG: begin
                // Attach as soon as the configuration is applied, forced at limit
                if (cfg_apply_done_i || tmr_exp) begin
                    st_next = hrs_pkg::HRS_ST_ATTACH;
                end
            end
            hrs_pkg::HRS_ST_ATTACH: begin
                st_next = hrs_pkg::HRS_ST_RUN;
            end
            hrs_pkg::HRS_ST_RUN: begin
                st_next = hrs_pkg::HRS_ST_RUN;
            end
            hrs_pkg::HRS_ST_FAULT: begin
                st_next = hrs_pkg::HRS_ST_FAULT;
            end
            default: begin
                st_next = hrs_pkg::HRS_ST_FAULT;
            end
        endcase
    end

    // USB device state, port power and translator flush
    always_comb begin
        usb_next   = usb_reg;
        pwr_next   = pwr_reg;
        flush_next = 1'b0;
        if (bus_reset_i) begin
            usb_next.dev_addr   = `HRS_DEFAULT_ADDR;
            usb_next.configured = 1'b0;
            usb_next.suspended  = 1'b0;
            pwr_next            = 2'h0;
            flush_next          = 1'b1;
        end else if (st_reg == hrs_pkg::HRS_ST_RUN) begin
            if (set_addr_i) begin
                usb_next.dev_addr = set_addr_val_i;
            end
            if (set_config_i) begin
                usb_next.configured = 1'b1;
            end
            usb_next.suspended = suspend_i;
            pwr_next = usb_reg.configured ? port_power_req_i : 2'h0;
        end
    end

    // Request completion watchdog
    always_comb begin
        req_act_next = req_act_reg;
        rto_next     = 1'b0;
        rq_load      = 1'b0;
        if (bus_reset_i || req_done_i) begin
            req_act_next = 1'b0;
        end else if (req_start_i && st_reg == hrs_pkg::HRS_ST_RUN) begin
            req_act_next = 1'b1;
            rq_load      = 1'b1;
        end else if (req_act_reg && rq_exp) begin
            req_act_next = 1'b0;
            rto_next     = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg      <= hrs_pkg::HRS_ST_STAB;
            usb_reg     <= '0;
            pwr_reg     <= 2'h0;
            start_reg   <= 1'b0;
            apply_reg   <= 1'b0;
            flush_reg   <= 1'b0;
            fault_reg   <= 1'b0;
            req_act_reg <= 1'b0;
            rto_reg     <= 1'b0;
            smb_was_reg <= 1'b0;
        end else begin
            st_reg      <= st_next;
            usb_reg     <= usb_next;
            pwr_reg     <= pwr_next;
            start_reg   <= start_next;
            apply_reg   <= apply_next;
            flush_reg   <= flush_next;
            fault_reg   <= fault_next;
            req_act_reg <= req_act_next;
            rto_reg     <= rto_next;
            smb_was_reg <= smb_was_next;
        end
    end

    // Stabilisation timer armed by the first edge after release
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= 1'b1;
        end
    end

    assign ee_fetch_start_o           = start_reg;
    assign cfg_apply_start_o          = apply_reg;
    assign attach_o                   = (st_reg == hrs_pkg::HRS_ST_RUN);
    assign downstream_port_power_en_o = pwr_reg;
    assign downstream_reset_o         = 1'b0;
    assign tt_flush_o                 = flush_reg;
    assign suspended_o                = usb_reg.suspended;
    assign configured_o               = usb_reg.configured;
    assign dev_addr_o                 = usb_reg.dev_addr;
    assign cfg_fault_o                = fault_reg;
    assign req_timeout_o              = rto_reg;

    // Phase timer takes the stabilisation count at the first edge after release
    assign stab_load = !armed_reg;

    property p_stab_min;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(armed_reg) |-> (st_reg == hrs_pkg::HRS_ST_STAB) [*8];
    endproperty
    a_stab_min: assert property (p_stab_min) else $error("left stabilisation early");

    property p_ee_start;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (st_reg == hrs_pkg::HRS_ST_STAB && st_next == hrs_pkg::HRS_ST_EE) |=> ee_fetch_start_o;
    endproperty
    a_ee_start: assert property (p_ee_start) else $error("EEPROM fetch not started");

    property p_bus_reset_addr;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        bus_reset_i |=> (dev_addr_o == 7'h00 && !configured_o && !suspended_o);
    endproperty
    a_bus_reset_addr: assert property (p_bus_reset_addr) else $error("bus reset state");

    property p_bus_reset_pwr;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        bus_reset_i |=> (downstream_port_power_en_o == 2'h0) && tt_flush_o;
    endproperty
    a_bus_reset_pwr: assert property (p_bus_reset_pwr) else $error("power or flush");

    property p_no_fwd;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        bus_reset_i |-> ##[0:2] !downstream_reset_o;
    endproperty
    a_no_fwd: assert property (p_no_fwd) else $error("reset forwarded");

    property p_self_wait;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (st_reg == hrs_pkg::HRS_ST_SMB && self_powered_i && !smb_load_done_i)
            |=> (st_reg == hrs_pkg::HRS_ST_SMB);
    endproperty
    a_self_wait: assert property (p_self_wait) else $error("self-powered wait broken");

    property p_attach_follow;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (st_reg == hrs_pkg::HRS_ST_CFG && cfg_apply_done_i) |-> ##2 attach_o;
    endproperty
    a_attach_follow: assert property (p_attach_follow) else $error("late attach");

    property p_cfg_fault;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (st_reg == hrs_pkg::HRS_ST_EE && tmr_exp && !ee_done_i) |=> cfg_fault_o;
    endproperty
    a_cfg_fault: assert property (p_cfg_fault) else $error("EEPROM timeout missed");
endmodule
`default_nettype wire

/* test/hrs_host_model.sv */
// Upstream host and configuration source model for the sequencer bench
`timescale 1ns/1ps
`default_nettype none
`include "hrs_consts.svh"
module hrs_host_model #(
    parameter int ATTACH_WAIT = `HRS_ATTACH_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        smbus_mode_i,
    input  wire logic [15:0] lag_i,
    input  wire logic        reset_req_i,
    input  wire logic        ee_fetch_start_i,
    input  wire logic        cfg_apply_start_i,
    input  wire logic        attach_i,
    output logic             ee_done_o,
    output logic             smb_load_done_o,
    output logic             cfg_apply_done_o,
    output logic             bus_reset_o
);
    int   ee_cnt, cfg_cnt, up_cnt, att_cnt, br_cnt;
    logic pend;
    logic start;
    // Bus reset only once the attach has been seen for the full wait
    assign start = pend && (att_cnt >= ATTACH_WAIT) && (br_cnt == 0);
    always @(negedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {ee_done_o, smb_load_done_o, cfg_apply_done_o, bus_reset_o, pend} <= '0;
            {ee_cnt, cfg_cnt, up_cnt, att_cnt, br_cnt} <= '0;
        end else begin
            up_cnt <= up_cnt + 1;
            ee_done_o <= (ee_cnt == 1);
            ee_cnt <= ee_fetch_start_i ? int'(lag_i) + 1 : (ee_cnt > 0 ? ee_cnt - 1 : 0);
            cfg_apply_done_o <= (cfg_cnt == 1);
            cfg_cnt <= cfg_apply_start_i ? int'(lag_i) + 1 : (cfg_cnt > 0 ? cfg_cnt - 1 : 0);
            // Load length chosen by the bench; self powered may run long
            if (smbus_mode_i && up_cnt >= `HRS_STAB_CYC + int'(lag_i)) begin
                smb_load_done_o <= 1'b1;
            end
            att_cnt <= attach_i ? att_cnt + 1 : 0;
            pend <= reset_req_i | (pend & ~start);
            br_cnt <= start ? 4 : (br_cnt > 0 ? br_cnt - 1 : 0);
            bus_reset_o <= start | (br_cnt > 1);
        end
    end
endmodule
`default_nettype wire

/* test/hrs_sequencer_tb.sv */
// Self-checking bench for the hub reset and configuration sequencer
`timescale 1ns/1ps
`default_nettype none
`include "hrs_consts.svh"
module hrs_sequencer_tb;
    localparam int WAIT_CYC = 200;
    logic        ref_clk_i, rst_b_i, smbus_mode_i, self_powered_i, suspend_i;
    logic        ee_done_i, smb_load_done_i, cfg_apply_done_i, bus_reset_i;
    logic        set_addr_i, set_config_i, req_start_i, req_done_i, reset_req;
    logic [6:0]  set_addr_val_i;
    logic [1:0]  port_power_req_i;
    logic [15:0] model_lag;
    logic        ee_fetch_start_o, cfg_apply_start_o, attach_o, downstream_reset_o;
    logic        tt_flush_o, suspended_o, configured_o, cfg_fault_o, req_timeout_o;
    logic [1:0]  downstream_port_power_en_o;
    logic [6:0]  dev_addr_o;
    int          mismatches, samples_checked, fetch_at, apply_at, attach_at, fetch_cnt;

    hrs_sequencer u_dut (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .smbus_mode_i(smbus_mode_i),
        .self_powered_i(self_powered_i), .ee_done_i(ee_done_i),
        .smb_load_done_i(smb_load_done_i), .cfg_apply_done_i(cfg_apply_done_i),
        .bus_reset_i(bus_reset_i), .suspend_i(suspend_i), .set_addr_i(set_addr_i),
        .set_addr_val_i(set_addr_val_i), .set_config_i(set_config_i),
        .port_power_req_i(port_power_req_i), .req_start_i(req_start_i),
        .req_done_i(req_done_i), .ee_fetch_start_o(ee_fetch_start_o),
        .cfg_apply_start_o(cfg_apply_start_o), .attach_o(attach_o),
        .downstream_port_power_en_o(downstream_port_power_en_o),
        .downstream_reset_o(downstream_reset_o), .tt_flush_o(tt_flush_o),
        .suspended_o(suspended_o), .configured_o(configured_o), .dev_addr_o(dev_addr_o),
        .cfg_fault_o(cfg_fault_o), .req_timeout_o(req_timeout_o)
    );

    // Short attach wait keeps the run small
    hrs_host_model #(.ATTACH_WAIT(WAIT_CYC)) u_host (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .smbus_mode_i(smbus_mode_i),
        .lag_i(model_lag), .reset_req_i(reset_req), .ee_fetch_start_i(ee_fetch_start_o),
        .cfg_apply_start_i(cfg_apply_start_o), .attach_i(attach_o), .ee_done_o(ee_done_i),
        .smb_load_done_o(smb_load_done_i), .cfg_apply_done_o(cfg_apply_done_i),
        .bus_reset_o(bus_reset_i)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Full start-up up to attach, logging when each milestone showed
    task automatic boot(input logic smb, input logic sp, input logic [15:0] lg);
        int n;
        @(negedge ref_clk_i);
        rst_b_i <= 1'b0;
        smbus_mode_i <= smb;
        self_powered_i <= sp;
        model_lag <= lg;
        repeat (20) @(negedge ref_clk_i);
        rst_b_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        check("quiet", 32'({attach_o, downstream_port_power_en_o, configured_o,
            dev_addr_o, cfg_fault_o, ee_fetch_start_o}), 32'h0);
        @(negedge ref_clk_i);
        set_addr_i <= 1'b1;
        set_addr_val_i <= 7'h11;
        @(negedge ref_clk_i);
        set_addr_i <= 1'b0;
        fetch_at = 0;
        apply_at = 0;
        attach_at = 0;
        fetch_cnt = 0;
        for (n = 3; n < 20000 && attach_at == 0; n++) begin
            @(posedge ref_clk_i);
            #1;
            if (ee_fetch_start_o === 1'b1) begin
                fetch_at = n;
                fetch_cnt++;
            end
            if (cfg_apply_done_i === 1'b1) apply_at = n;
            if (attach_o === 1'b1) attach_at = n;
        end
        check("early address", 32'(dev_addr_o), 32'h0);
        // Done is seen at the edge that takes it, attach just after the next edge
        check("attach lag", 32'(attach_at - apply_at), 32'h1);
        check("fault", 32'(cfg_fault_o), 32'h0);
    endtask

    task automatic t_ee_boot();
        boot(1'b0, 1'b0, 16'd20);
        check("fetch count", 32'(fetch_cnt), 32'h1);
        check("fetch time", 32'(fetch_at <= `HRS_STAB_CYC + 2), 32'h1);
    endtask

    task automatic t_smb(input logic sp, input logic [15:0] lg);
        boot(1'b1, sp, lg);
        check("no fetch", 32'(fetch_cnt), 32'h0);
        check("load awaited", 32'(attach_at > `HRS_STAB_CYC + int'(lg)), 32'h1);
    endtask

    task automatic t_bus_reset();
        int n;
        @(negedge ref_clk_i);
        set_addr_i <= 1'b1;
        set_addr_val_i <= 7'h2A;
        set_config_i <= 1'b1;
        port_power_req_i <= 2'h3;
        suspend_i <= 1'b1;
        @(negedge ref_clk_i);
        set_addr_i <= 1'b0;
        set_config_i <= 1'b0;
        reset_req <= 1'b1;
        @(negedge ref_clk_i);
        reset_req <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        check("address set", 32'(dev_addr_o), 32'h2A);
        check("setup", 32'({configured_o, downstream_port_power_en_o, suspended_o}), 32'hF);
        for (n = 0; n < WAIT_CYC + 50 && bus_reset_i !== 1'b1; n++) @(posedge ref_clk_i);
        // Suspend drops only after the reset edge, so wake-up is the reset's doing
        @(negedge ref_clk_i);
        suspend_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        check("address cleared", 32'(dev_addr_o), 32'h0);
        check("unconfigured", 32'(configured_o), 32'h0);
        check("port power", 32'(downstream_port_power_en_o), 32'h0);
        check("tt flush", 32'(tt_flush_o), 32'h1);
        check("awake", 32'(suspended_o), 32'h0);
        check("no forward", 32'(downstream_reset_o), 32'h0);
    endtask

    task automatic t_req();
        int n;
        logic seen;
        repeat (8) @(negedge ref_clk_i);
        set_addr_i <= 1'b1;
        set_addr_val_i <= 7'h05;
        req_start_i <= 1'b1;
        @(negedge ref_clk_i);
        set_addr_i <= 1'b0;
        req_start_i <= 1'b0;
        repeat (10) @(negedge ref_clk_i);
        req_done_i <= 1'b1;
        @(negedge ref_clk_i);
        req_done_i <= 1'b0;
        check("host address", 32'(dev_addr_o), 32'h05);
        seen = 1'b0;
        repeat (`HRS_REQ_MAX_CYC + 20) begin
            @(posedge ref_clk_i);
            #1;
            seen = seen | req_timeout_o;
        end
        check("answered request", 32'(seen), 32'h0);
        @(negedge ref_clk_i);
        req_start_i <= 1'b1;
        @(negedge ref_clk_i);
        req_start_i <= 1'b0;
        for (n = 1; n < `HRS_REQ_MAX_CYC + 50 && req_timeout_o !== 1'b1; n++) begin
            @(posedge ref_clk_i);
            #1;
        end
        check("request limit", 32'(n >= `HRS_REQ_MAX_CYC - 3 && n <= `HRS_REQ_MAX_CYC + 3),
            32'h1);
    endtask

    initial begin
        mismatches = 0;
        samples_checked = 0;
        {rst_b_i, smbus_mode_i, self_powered_i, suspend_i, reset_req} = '0;
        {set_addr_i, set_config_i, req_start_i, req_done_i} = '0;
        set_addr_val_i = 7'h00;
        port_power_req_i = 2'h0;
        model_lag = 16'h0000;
        t_ee_boot();
        t_bus_reset();
        t_req();
        t_smb(1'b0, 16'd100);
        t_smb(1'b1, 16'd3000);
        wrap_up();
    end

    // About 120k cycles expected, mostly the two 5 ms request windows
    initial begin
        repeat (150000) @(posedge ref_clk_i);
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
